// >>> design/mrse_pkg.sv
package mrse_pkg;

  // sample classification carried in the three top header bits
  localparam logic [2:0] FLAG_PLAIN    = 3'h0;
  localparam logic [2:0] FLAG_GO       = 3'h1;
  localparam logic [2:0] FLAG_LO       = 3'h2;
  localparam logic [2:0] FLAG_HI       = 3'h3;
  localparam logic [2:0] FLAG_LIMITER  = 3'h4;
  localparam logic [2:0] FLAG_UNSTABLE = 3'h5;
  localparam logic [2:0] FLAG_OVER     = 3'h6;

  // range code bases: code = base + ascending range index
  localparam logic [3:0] RANGE_BASE_VOLT = 4'h4;
  localparam logic [3:0] RANGE_BASE_CURR = 4'h3;
  localparam logic [2:0] RANGE_MAX_VOLT  = 3'h3;
  localparam logic [2:0] RANGE_MAX_CURR  = 3'h6;

  // data field widths and spans
  localparam int         DATA_W       = 24;
  localparam logic [2:0] BYTES_COARSE = 3'h2;
  localparam logic [2:0] BYTES_FINE   = 3'h3;
  localparam int         SPAN_COARSE  = 32000;
  localparam int         SPAN_FINE    = 320000;

  // ascii record headers
  localparam logic [7:0] CHR_D = 8'h44;
  localparam logic [7:0] CHR_C = 8'h43;
  localparam logic [7:0] CHR_S = 8'h53;

  // status byte bit positions
  localparam int SB_OPER_OFF = 7;
  localparam int SB_SRQ      = 6;
  localparam int SB_TRIGGER  = 5;
  localparam int SB_UNUSED   = 4;
  localparam int SB_LEVEL_A  = 3;
  localparam int SB_LEVEL_B  = 2;
  localparam int SB_SYNTAX   = 1;
  localparam int SB_FAULT    = 0;

  // operation status bit positions
  localparam int OP_LIMITER  = 7;
  localparam int OP_UNSTABLE = 6;
  localparam int OP_OVERHEAT = 5;
  localparam int OP_OVERLOAD = 4;
  localparam int OP_SWEEP    = 1;
  localparam int OP_OPERATE  = 0;

  // reset values
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET   = 8'hff;
  localparam logic [7:0] ZERO_BYTE    = 8'h00;

  // staging register holds up to five bytes of one record
  localparam int         STAGE_BYTES = 5;
  localparam int         STAGE_W     = STAGE_BYTES * 8;

  typedef enum logic [1:0] {
    MODE_BUFFER,
    MODE_COUNT,
    MODE_OPSTAT
  } mrse_mode_t;

  typedef struct packed {
    logic [2:0]        flag;
    logic              is_volt;
    logic [2:0]        range_idx;
    logic [DATA_W-1:0] value;
  } mrse_sample_t;

  typedef struct packed {
    logic       last;
    logic [7:0] data;
  } mrse_byte_t;

endpackage

// >>> design/mrse_fifo.sv
`timescale 1ns/1ps
module mrse_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  output      logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output      logic             out_valid_o,
  input  wire logic             out_ready_i,
  output      logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [WIDTH-1:0] head_q;
  wire              push;
  wire              pop;
  wire  [AW-1:0]    rd_next;

  assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;
  assign rd_next     = (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
  assign out_data_o  = head_q;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

  // head word kept in a register; bypass when the fifo is empty or runs dry
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      wr_q   <= '0;
      rd_q   <= '0;
      cnt_q  <= '0;
      head_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_next;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (push && (cnt_q == '0 || (pop && cnt_q == (AW+1)'(1)))) begin
        head_q <= in_data_i;
      end else if (pop) begin
        head_q <= mem_q[rd_next];
      end
    end
  end

endmodule // mrse_fifo

// >>> design/mrse_encoder.sv
// Functional notes
// - header bits 7..5 classify the sample
// - header bit 4 high for voltage data
// - data sent as two's-complement displayed count
// - two bytes coarse, three bytes fine resolution
// - count record sixteen bits, high byte first
// - count record only after its select command
// - two-letter header only while headers enabled
// - operation status sent as one byte
// - bits 7,6 follow limiter and oscillation
// - bits 5,4 sticky until operation restarts
// - status byte level selected by commands
// - status bit 7 set by operate-off
// - serial poll clears status bit 7
// - bit 6 on unmasked bits; raise SRQ
// - serial poll clears status bit 6; stays set while unmasked bit 1, 3 or 0 is set
// - bit 5 trigger, cleared by poll
// - bit 1 errors, cleared by good block
// - clear command and reset clear status
`timescale 1ns/1ps
module mrse_encoder #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic                  CLK_I,
  input  wire logic                  SRST_I,
  // output-mode and setting commands, one-cycle strobes
  input  wire logic                  BUFFER_STORE_ON_I,
  input  wire logic                  SELECT_COUNT_OUTPUT_I,
  input  wire logic                  SELECT_OPSTATUS_OUTPUT_I,
  input  wire logic                  HEADER_ON_CMD_I,
  input  wire logic                  HEADER_OFF_CMD_I,
  input  wire logic                  STATUS_LEVEL0_CMD_I,
  input  wire logic                  STATUS_LEVEL1_CMD_I,
  input  wire logic                  STATUS_MASK_CMD_I,
  input  wire logic [7:0]            STATUS_MASK_I,
  input  wire logic                  CLEAR_CMD_I,
  input  wire logic                  CMD_ERROR_I,
  input  wire logic                  CMD_GOOD_BLOCK_I,
  // levels from the instrument
  input  wire logic                  FINE_RESOLUTION_I,
  input  wire logic                  SRQ_ENABLE_I,
  input  wire logic [15:0]           STORED_COUNT_I,
  input  wire logic                  LIMITER_ACTIVE_I,
  input  wire logic                  OSCILLATION_DETECTED_I,
  input  wire logic                  OVERHEAT_DETECTED_I,
  input  wire logic                  OVERLOAD_DETECTED_I,
  input  wire logic                  OPERATION_START_I,
  input  wire logic                  SWEEP_RUNNING_I,
  input  wire logic                  OPERATING_I,
  input  wire logic                  BUFFER_FULL_I,
  input  wire logic                  OPERATE_OFF_IN_I,
  input  wire logic                  EXT_TRIGGER_IN_I,
  // talker addressed: start one record
  input  wire logic                  TALK_I,
  // measurement samples
  input  wire logic                  SAMPLE_VALID_I,
  output      logic                  SAMPLE_READY_O,
  input  wire mrse_pkg::mrse_sample_t SAMPLE_I,
  // record byte stream, last marks the block delimiter point
  output      logic                  BYTE_VALID_O,
  input  wire logic                  BYTE_READY_I,
  output      logic [7:0]            BYTE_O,
  output      logic                  BYTE_LAST_O,
  output      logic                  BUSY_O,
  // status byte read by serial poll
  input  wire logic                  SERIAL_POLL_I,
  output      logic [7:0]            STATUS_BYTE_O,
  output      logic [7:0]            OP_STATUS_O,
  output      logic                  SRQ_O
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_WAIT_SAMPLE,
    ST_SEND
  } mrse_state_t;

  function automatic logic [3:0] range_code(input logic is_volt, input logic [2:0] idx);
    logic [2:0] lim;
    lim = is_volt ? mrse_pkg::RANGE_MAX_VOLT : mrse_pkg::RANGE_MAX_CURR;
    if (idx > lim) begin
      idx = lim;
    end
    range_code = (is_volt ? mrse_pkg::RANGE_BASE_VOLT : mrse_pkg::RANGE_BASE_CURR)
                 + {1'b0, idx};
  endfunction

  mrse_pkg::mrse_mode_t         mode_q;
  mrse_state_t                  state_q;
  mrse_state_t                  state_d;
  logic                         header_en_q;
  logic                         level1_q;
  logic [7:0]                   mask_q;
  logic [7:0]                   op_q;
  logic [7:0]                   sb_q;
  logic [mrse_pkg::STAGE_W-1:0] stage_q;
  logic [mrse_pkg::STAGE_W-1:0] stage_d;
  logic [2:0]                   left_q;
  logic [2:0]                   left_d;
  mrse_pkg::mrse_byte_t         push_byte;
  mrse_pkg::mrse_byte_t         pop_byte;

  wire        fifo_ready;
  wire        push;
  wire        take_sample;
  wire [7:0]  hdr_byte;
  wire [7:0]  op_d;
  wire [7:0]  sb_live;
  wire [7:0]  sb_set;
  wire [7:0]  sb_clr;
  wire [7:0]  sb_d;
  wire [7:0]  sb_pre;
  wire [2:0]  data_bytes;
  wire [mrse_pkg::STAGE_W-1:0] sample_stage;
  wire [mrse_pkg::STAGE_W-1:0] count_stage;
  wire [mrse_pkg::STAGE_W-1:0] opstat_stage;

  // header byte of a binary buffer record
  // classification flag
  assign hdr_byte = {SAMPLE_I.flag, SAMPLE_I.is_volt,
                     range_code(SAMPLE_I.is_volt, SAMPLE_I.range_idx)};
  assign data_bytes = FINE_RESOLUTION_I ? mrse_pkg::BYTES_FINE : mrse_pkg::BYTES_COARSE;
  // signed value sent as is, high byte first; coarse drops the top byte
  assign sample_stage = FINE_RESOLUTION_I
    ? {hdr_byte, SAMPLE_I.value, mrse_pkg::ZERO_BYTE}
    : {hdr_byte, SAMPLE_I.value[15:0], mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE};

  assign count_stage = header_en_q
    ? {mrse_pkg::CHR_D, mrse_pkg::CHR_C, STORED_COUNT_I, mrse_pkg::ZERO_BYTE}
    : {STORED_COUNT_I, mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE};
  assign opstat_stage = header_en_q
    ? {mrse_pkg::CHR_S, mrse_pkg::CHR_S, op_q, mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE}
    : {op_q, mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE, mrse_pkg::ZERO_BYTE,
       mrse_pkg::ZERO_BYTE};
  assign take_sample    = (state_q == ST_WAIT_SAMPLE) & SAMPLE_VALID_I;
  assign SAMPLE_READY_O = (state_q == ST_WAIT_SAMPLE);
  // back-pressure from the fifo stalls the byte sequencer
  assign push           = (state_q == ST_SEND) & fifo_ready;
  assign push_byte.data = stage_q[mrse_pkg::STAGE_W-1 -: 8];
  assign push_byte.last = (left_q == 3'h1);
  assign BUSY_O         = (state_q != ST_IDLE);
  always_comb begin
    state_d = state_q;
    stage_d = stage_q;
    left_d  = left_q;
    case (state_q)
      ST_IDLE: begin
        if (TALK_I) begin
          case (mode_q)
            mrse_pkg::MODE_COUNT: begin
              stage_d = count_stage;
              left_d  = header_en_q ? 3'h4 : 3'h2;
              state_d = ST_SEND;
            end
            mrse_pkg::MODE_OPSTAT: begin
              stage_d = opstat_stage;
              left_d  = header_en_q ? 3'h3 : 3'h1;
              state_d = ST_SEND;
            end
            default: begin
              state_d = ST_WAIT_SAMPLE;
            end
          endcase
        end
      end
      ST_WAIT_SAMPLE: begin
        if (take_sample) begin
          stage_d = sample_stage;
          left_d  = data_bytes + 3'h1;
          state_d = ST_SEND;
        end
      end
      ST_SEND: begin
        if (push) begin
          stage_d = {stage_q[mrse_pkg::STAGE_W-9:0], mrse_pkg::ZERO_BYTE};
          left_d  = left_q - 3'h1;
          if (left_q == 3'h1) begin
            state_d = ST_IDLE;
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      state_q <= ST_IDLE;
      stage_q <= '0;
      left_q  <= '0;
    end else begin
      state_q <= state_d;
      stage_q <= stage_d;
      left_q  <= left_d;
    end
  end

  // output mode and header switch
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      mode_q      <= mrse_pkg::MODE_BUFFER;
      header_en_q <= 1'b1;
    end else begin
      if (SELECT_COUNT_OUTPUT_I) begin
        mode_q <= mrse_pkg::MODE_COUNT;
      end else if (SELECT_OPSTATUS_OUTPUT_I) begin
        mode_q <= mrse_pkg::MODE_OPSTAT;
      end else if (BUFFER_STORE_ON_I) begin
        mode_q <= mrse_pkg::MODE_BUFFER;
      end
      if (HEADER_ON_CMD_I) begin
        header_en_q <= 1'b1;
      end else if (HEADER_OFF_CMD_I) begin
        header_en_q <= 1'b0;
      end
    end
  end

  // operation status, sticky bits: a new detection beats the restart clear
  // follow detections
  assign op_d = {LIMITER_ACTIVE_I,
                 OSCILLATION_DETECTED_I,
                 OVERHEAT_DETECTED_I | (op_q[mrse_pkg::OP_OVERHEAT] & ~OPERATION_START_I),
                 OVERLOAD_DETECTED_I | (op_q[mrse_pkg::OP_OVERLOAD] & ~OPERATION_START_I),
                 2'b00,
                 SWEEP_RUNNING_I,
                 OPERATING_I};

  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      op_q <= mrse_pkg::STATUS_RESET;
    end else begin
      op_q <= op_d;
    end
  end

  // status level and mask
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      level1_q <= 1'b0;
      mask_q   <= mrse_pkg::MASK_RESET;
    end else begin
      if (STATUS_LEVEL1_CMD_I) begin
        level1_q <= 1'b1;
      end else if (STATUS_LEVEL0_CMD_I) begin
        level1_q <= 1'b0;
      end
      if (STATUS_MASK_CMD_I) begin
        mask_q <= STATUS_MASK_I;
      end
    end
  end

  // level bits: only buffer-full is modelled, at level 1; bit 4 never used
  assign sb_live = {1'b0, 1'b0, 1'b0, 1'b0,
                    level1_q & BUFFER_FULL_I,
                    1'b0,
                    1'b0,
                    LIMITER_ACTIVE_I | OSCILLATION_DETECTED_I};
  // events set; set wins over every clear in the same cycle
  // operate-off sets bit 7
  assign sb_set = {OPERATE_OFF_IN_I,
                   |(sb_pre & ~mask_q),
                   EXT_TRIGGER_IN_I,
                   1'b0, 1'b0, 1'b0,
                   CMD_ERROR_I,
                   1'b0};
  // summary sees bits 7,5,1 after clears plus live bits 3,0; a poll empties bit 6 only if bits 1,3,0 are clear or masked
  assign sb_pre = {sb_q[7] & ~sb_clr[7], 1'b0, sb_q[5] & ~sb_clr[5], sb_live[4:2],
                   sb_q[1] & ~sb_clr[1], sb_live[0]};
  assign sb_clr = {{3{SERIAL_POLL_I | CLEAR_CMD_I}},
                   3'b000,
                   CMD_GOOD_BLOCK_I | CLEAR_CMD_I,
                   1'b0};

  assign sb_d = {(sb_q[7:5] & ~sb_clr[7:5]) | sb_set[7:5],
                 sb_live[4:2],
                 (sb_q[1] & ~sb_clr[1]) | sb_set[1],
                 sb_live[0]};
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      sb_q <= mrse_pkg::STATUS_RESET;
    end else begin
      sb_q <= sb_d;
    end
  end

  assign STATUS_BYTE_O = sb_q;
  assign OP_STATUS_O   = op_q;
  assign SRQ_O = sb_q[mrse_pkg::SB_SRQ] & SRQ_ENABLE_I;
  // bytes queue here so a slow bus stalls the sequencer, not the samples
  mrse_fifo #(
    .WIDTH ($bits(mrse_pkg::mrse_byte_t)),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_i       (CLK_I),
    .srst_i      (SRST_I),
    .in_valid_i  (state_q == ST_SEND),
    .in_ready_o  (fifo_ready),
    .in_data_i   (push_byte),
    .out_valid_o (BYTE_VALID_O),
    .out_ready_i (BYTE_READY_I),
    .out_data_o  (pop_byte)
  );
  assign BYTE_O      = pop_byte.data;
  assign BYTE_LAST_O = pop_byte.last;

endmodule // mrse_encoder

// >>> sim/mrse_host.sv
`timescale 1ns/1ps
module mrse_host (
  input  wire logic       clk_i,
  input  wire logic       stall_i,
  input  wire logic       valid_i,
  input  wire logic [7:0] data_i,
  input  wire logic       last_i,
  output      logic       ready_o
);
  logic [8:0] got_q[$];
  initial ready_o = 1'b0;
  // a slow host drops ready, so bytes must wait at the device
  always @(negedge clk_i) ready_o <= !stall_i;
  // bytes taken on the handshake edge only
  always @(posedge clk_i) if (valid_i && ready_o) got_q.push_back({last_i, data_i});
endmodule // mrse_host

// >>> sim/mrse_encoder_chk.sv
`timescale 1ns/1ps
module mrse_encoder_chk (
  input wire logic       CLK_I,
  input wire logic       SRST_I,
  input wire logic       SERIAL_POLL_I,
  input wire logic       OPERATE_OFF_IN_I,
  input wire logic       EXT_TRIGGER_IN_I,
  input wire logic       CMD_ERROR_I,
  input wire logic       CMD_GOOD_BLOCK_I,
  input wire logic       SRQ_ENABLE_I,
  input wire logic       LIMITER_ACTIVE_I,
  input wire logic       OPERATION_START_I,
  input wire logic       BYTE_VALID_O,
  input wire logic       BYTE_READY_I,
  input wire logic [7:0] BYTE_O,
  input wire logic [7:0] STATUS_BYTE_O,
  input wire logic [7:0] OP_STATUS_O,
  input wire logic       SRQ_O
);
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);
  opoff_set_a: assert property (OPERATE_OFF_IN_I |=> STATUS_BYTE_O[7])
    else $error("operate-off did not set status bit 7");
  // set wins over clear, so only a quiet poll must clear
  poll_clr_a: assert property (SERIAL_POLL_I && !OPERATE_OFF_IN_I && !EXT_TRIGGER_IN_I
    |=> !STATUS_BYTE_O[7] && !STATUS_BYTE_O[5]) else $error("poll left bit 7 or 5 set");
  poll_srq_a: assert property (SERIAL_POLL_I && !OPERATE_OFF_IN_I && !EXT_TRIGGER_IN_I
    && !STATUS_BYTE_O[1] |=> !STATUS_BYTE_O[6] || STATUS_BYTE_O[3] || STATUS_BYTE_O[0])
    else $error("poll left service bit 6 set");
  trig_set_a: assert property (EXT_TRIGGER_IN_I |=> STATUS_BYTE_O[5])
    else $error("trigger did not set status bit 5");
  err_set_a: assert property (CMD_ERROR_I |=> STATUS_BYTE_O[1])
    else $error("command error did not set bit 1");
  good_clr_a: assert property (CMD_GOOD_BLOCK_I && !CMD_ERROR_I |=> !STATUS_BYTE_O[1])
    else $error("good block did not clear bit 1");
  srq_out_a: assert property (SRQ_O == (STATUS_BYTE_O[6] && SRQ_ENABLE_I))
    else $error("service request mismatch");
  op_live_a: assert property (!$past(SRST_I) |-> OP_STATUS_O[7] == $past(LIMITER_ACTIVE_I))
    else $error("op bit 7 not following limiter");
  op_sticky_a: assert property (OP_STATUS_O[5] && !OPERATION_START_I |=> OP_STATUS_O[5])
    else $error("overheat bit dropped early");
  byte_hold_a: assert property (BYTE_VALID_O && !BYTE_READY_I
    |=> BYTE_VALID_O && $stable(BYTE_O)) else $error("byte changed while stalled");
  cover property (BYTE_VALID_O && !BYTE_READY_I);
  cover property ($rose(SRQ_O));
  cover property (SERIAL_POLL_I && STATUS_BYTE_O[6]);
endmodule // mrse_encoder_chk

bind mrse_encoder mrse_encoder_chk i_mrse_encoder_chk (
  .CLK_I(CLK_I), .SRST_I(SRST_I), .SERIAL_POLL_I(SERIAL_POLL_I),
  .OPERATE_OFF_IN_I(OPERATE_OFF_IN_I), .EXT_TRIGGER_IN_I(EXT_TRIGGER_IN_I),
  .CMD_ERROR_I(CMD_ERROR_I), .CMD_GOOD_BLOCK_I(CMD_GOOD_BLOCK_I), .SRQ_ENABLE_I(SRQ_ENABLE_I),
  .LIMITER_ACTIVE_I(LIMITER_ACTIVE_I), .OPERATION_START_I(OPERATION_START_I),
  .BYTE_VALID_O(BYTE_VALID_O), .BYTE_READY_I(BYTE_READY_I), .BYTE_O(BYTE_O),
  .STATUS_BYTE_O(STATUS_BYTE_O), .OP_STATUS_O(OP_STATUS_O), .SRQ_O(SRQ_O));

// >>> sim/mrse_encoder_tb.sv
`timescale 1ns/1ps
module mrse_encoder_tb;
  logic        clk = 1'b0;
  logic        srst = 1'b1;
  logic [15:0] cmd = '0;
  logic [9:0]  lvl = '0;
  logic [7:0]  mask = '0;
  logic [15:0] cnt = '0;
  logic [7:0]  hdr;
  logic        stall = 1'b0;
  mrse_pkg::mrse_sample_t samp = '0;
  wire         s_rdy, b_vld, b_rdy, b_last, busy, srq;
  wire  [7:0]  b_dat, sb, op;
  logic [8:0]  exp_q[$];
  int          mismatches = 0;
  int          samples_checked = 0;
  int          cycles = 0;

  mrse_encoder i_mrse_encoder (.CLK_I(clk), .SRST_I(srst), .BUFFER_STORE_ON_I(cmd[0]),
    .SELECT_COUNT_OUTPUT_I(cmd[1]), .SELECT_OPSTATUS_OUTPUT_I(cmd[2]),
    .HEADER_ON_CMD_I(cmd[3]), .HEADER_OFF_CMD_I(cmd[4]), .STATUS_LEVEL0_CMD_I(cmd[5]),
    .STATUS_LEVEL1_CMD_I(cmd[6]), .STATUS_MASK_CMD_I(cmd[7]), .STATUS_MASK_I(mask),
    .CLEAR_CMD_I(cmd[8]), .CMD_ERROR_I(cmd[9]), .CMD_GOOD_BLOCK_I(cmd[10]),
    .FINE_RESOLUTION_I(lvl[1]), .SRQ_ENABLE_I(lvl[2]), .STORED_COUNT_I(cnt),
    .LIMITER_ACTIVE_I(lvl[3]), .OSCILLATION_DETECTED_I(lvl[4]), .OVERHEAT_DETECTED_I(lvl[5]),
    .OVERLOAD_DETECTED_I(lvl[6]), .OPERATION_START_I(cmd[13]), .SWEEP_RUNNING_I(lvl[7]),
    .OPERATING_I(lvl[8]), .BUFFER_FULL_I(lvl[9]), .OPERATE_OFF_IN_I(cmd[14]),
    .EXT_TRIGGER_IN_I(cmd[15]), .TALK_I(cmd[11]), .SAMPLE_VALID_I(lvl[0]),
    .SAMPLE_READY_O(s_rdy), .SAMPLE_I(samp), .BYTE_VALID_O(b_vld), .BYTE_READY_I(b_rdy),
    .BYTE_O(b_dat), .BYTE_LAST_O(b_last), .BUSY_O(busy), .SERIAL_POLL_I(cmd[12]),
    .STATUS_BYTE_O(sb), .OP_STATUS_O(op), .SRQ_O(srq));

  mrse_host i_mrse_host (.clk_i(clk), .stall_i(stall), .valid_i(b_vld), .data_i(b_dat),
    .last_i(b_last), .ready_o(b_rdy));

  initial begin
    forever #2 clk = ~clk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      end_of_test;
    end
  end

  task automatic strobe(input int b);
    @(negedge clk);
    cmd[b] = 1'b1;
    @(negedge clk);
    cmd[b] = 1'b0;
  endtask

  task automatic check(input string what, input logic [8:0] e, input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", what, e, g);
      mismatches++;
    end
  endtask

  // one talk cycle; the host may stall for the first few cycles
  task automatic rec(input bit smp);
    int n;
    n = exp_q.size();
    strobe(11);
    if (smp) begin
      lvl[0] = 1'b1;
      for (int t = 0; t < 50 && s_rdy !== 1'b1; t++) @(negedge clk);
      @(negedge clk);
      lvl[0] = 1'b0;
    end
    for (int t = 0; t < 200 && i_mrse_host.got_q.size() < n; t++) begin
      @(negedge clk);
      if (t == 8) stall = 1'b0;
    end
    check("record length", 9'(n), 9'(i_mrse_host.got_q.size()));
    check("busy", 9'h000, {8'h00, busy});
    for (int i = 0; i < n; i++) check("record byte", exp_q[i], i_mrse_host.got_q[i]);
    exp_q.delete();
    i_mrse_host.got_q.delete();
  endtask

  initial begin
    repeat (6) @(negedge clk);
    srst = 1'b0;
    check("status", 9'h000, {1'b0, sb});
    check("opstat", 9'h000, {1'b0, op});
    cnt = 16'h1387;
    strobe(1);
    stall = 1'b1;
    exp_q = '{9'h044, 9'h043, 9'h013, 9'h187};
    rec(1'b0);
    strobe(4);
    cnt = 16'h0b80;
    exp_q = '{9'h00b, 9'h180};
    rec(1'b0);
    strobe(3);
    lvl = 10'h1a8;
    @(negedge clk);
    lvl = 10'h188;
    @(negedge clk);
    check("opstat", 9'h0a3, {1'b0, op});
    strobe(2);
    exp_q = '{9'h053, 9'h053, 9'h1a3};
    rec(1'b0);
    strobe(13);
    lvl = 10'h1d0;
    @(negedge clk);
    lvl = 10'h190;
    repeat (2) @(negedge clk);
    check("opstat", 9'h053, {1'b0, op});
    lvl = '0;
    strobe(13);
    @(negedge clk);
    check("opstat", 9'h000, {1'b0, op});
    strobe(0);
    for (int i = 0; i < 7; i++) begin
      lvl[1] = i[0];
      samp.flag = i[2:0];
      samp.is_volt = i[0];
      samp.range_idx = i[0] ? 3'((i + 1) >> 1) : i[2:0];
      samp.value = i[0] ? 24'hfb1e00 : 24'h007d00;
      hdr = {i[2:0], i[0], i[0] ? 4'h4 + 4'((i + 1) >> 1) : 4'h3 + 4'(i)};
      exp_q = '{{1'b0, hdr}, 9'h07d, 9'h100};
      if (lvl[1]) exp_q = '{{1'b0, hdr}, 9'h0fb, 9'h01e, 9'h100};
      rec(1'b1);
    end
    mask = 8'h5f;
    strobe(7);
    lvl[2] = 1'b1;
    strobe(14);
    repeat (2) @(negedge clk);
    check("status", 9'h0c0, {1'b0, sb});
    check("srq", 9'h001, {8'h00, srq});
    strobe(12);
    check("status", 9'h000, {1'b0, sb});
    check("srq", 9'h000, {8'h00, srq});
    mask = 8'hff;
    strobe(7);
    strobe(15);
    strobe(9);
    lvl[3] = 1'b1;
    @(negedge clk);
    check("status", 9'h023, {1'b0, sb});
    strobe(10);
    lvl[3] = 1'b0;
    @(negedge clk);
    check("status", 9'h020, {1'b0, sb});
    strobe(6);
    lvl[9] = 1'b1;
    @(negedge clk);
    check("status", 9'h028, {1'b0, sb});
    strobe(5);
    @(negedge clk);
    check("status", 9'h020, {1'b0, sb});
    strobe(8);
    check("status", 9'h000, {1'b0, sb});
    end_of_test;
  end
endmodule // mrse_encoder_tb
